// ### hw/mros_defs.svh
// register map, field positions, reset values and text codes of the output selector
`ifndef MROS_DEFS_SVH
`define MROS_DEFS_SVH

`define MROS_OFS_CTRL      8'h00
`define MROS_OFS_MASK      8'h04
`define MROS_OFS_CMD       8'h08
`define MROS_OFS_STAT      8'h0C

`define MROS_CTRL_AUTO_BIT 0
`define MROS_CMD_QUERY_BIT 0
`define MROS_STAT_BUSY_BIT 0
`define MROS_STAT_PEND_BIT 1
`define MROS_STAT_OVL_BIT  2
`define MROS_STAT_GPIB_BIT 3
`define MROS_STAT_LVL_LSB  4

`define MROS_RST_AUTO      1'b0
`define MROS_RST_MASK      8'h14
`define MROS_ITEM_MASK     7'h7F
`define MROS_ITEM_CNT      3'h7

`define MROS_CHR_COMMA     8'h2C
`define MROS_CHR_TERM      8'h0A
`define MROS_CHR_ZERO      8'h30
`define MROS_CHR_ALPHA     8'h37

`endif

// ### hw/mros_fifo.sv
// byte fifo with registered output stage
`timescale 1ns/10ps
module mros_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output      logic                     in_ready,
  output      logic [WIDTH-1:0]         out_data,
  output      logic                     out_valid,
  input  wire logic                     out_ready,
  output      logic [$clog2(DEPTH):0]   level
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             out_valid_ff;
  logic             wr;
  logic             load;

  // full stalls the writer, so back-pressure reaches the formatter
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign wr        = in_valid & in_ready;
  assign load      = (cnt_ff != '0) & (~out_valid_ff | out_ready);
  assign out_data  = out_data_ff;
  assign out_valid = out_valid_ff;
  assign level     = cnt_ff;

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (ce && wr) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else if (ce) begin
      if (wr) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (load) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST) ? '0 : rd_ptr_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(wr) - (AW+1)'(load);
    end
  end

  // output register keeps the top-level outputs flop driven
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_data_ff  <= '0;
      out_valid_ff <= 1'b0;
    end else if (ce) begin
      if (load) begin
        out_data_ff  <= mem[rd_ptr_ff];
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

endmodule

// ### hw/mros_pkg.sv
// types shared by the result output selector
package mros_pkg;

  // formatter states, one-hot
  typedef enum logic [4:0] {
    st_idle  = 5'b00001,
    st_scan  = 5'b00010,
    st_comma = 5'b00100,
    st_digit = 5'b01000,
    st_term  = 5'b10000
  } mros_state_t;

endpackage

// ### hw/mros_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module mros_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// ### hw/mros_top.sv
// measurement result output selector: apb registers, formatter, tx fifo
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`include "mros_defs.svh"

// Functional notes
// - auto on: push result after each measurement
// - auto off: nothing sent on completion
// - pushed result uses query response layout
// - no automatic push over the gpib link
// - auto push settable and readable as on/off
// - selection mask holds 0 to 255
// - mask chooses items in query response
// - bit n selects item n, bit7 unused
// - mask 20 gives capacitance and loss values
module mros_top #(
  parameter int ADDR_W = 8,
  parameter int ITEM_W = 16,
  parameter int FIFO_D = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              pclk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              meas_done_pin,
  input  wire logic              link_gpib_pin,
  input  wire logic [ITEM_W-1:0] item_load_no,
  input  wire logic [ITEM_W-1:0] item_d_judge,
  input  wire logic [ITEM_W-1:0] item_d_value,
  input  wire logic [ITEM_W-1:0] item_c_judge,
  input  wire logic [ITEM_W-1:0] item_c_value,
  input  wire logic [ITEM_W-1:0] item_sorting_class,
  input  wire logic [ITEM_W-1:0] item_status,
  output      logic [7:0]        tx_data,
  output      logic              tx_valid,
  input  wire logic              tx_ready
);

  localparam int NIB   = ITEM_W / 4;
  localparam int NW    = (NIB > 1) ? $clog2(NIB) : 1;
  localparam int LVL_W = $clog2(FIFO_D) + 1;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]               pins_s;
  logic                     meas_s;
  logic                     gpib_s;
  logic                     meas_d_ff;
  logic                     meas_rise;

  logic                     auto_ff;
  logic [7:0]               mask_ff;
  logic                     push_pend_ff;
  logic                     query_pend_ff;
  logic                     ovl_ff;

  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic                     access;
  logic                     commit;
  logic                     hit;
  logic [31:0]              rd_val;
  logic                     query_evt;
  logic                     push_evt;
  logic                     start;

  mros_pkg::mros_state_t    state_ff;
  mros_pkg::mros_state_t    nxt_state;
  logic [2:0]               idx_ff;
  logic [2:0]               nxt_idx;
  logic [NW-1:0]            nib_ff;
  logic [NW-1:0]            nxt_nib;
  logic                     first_ff;
  logic                     nxt_first;
  logic [6:0]               sel_ff;
  logic [ITEM_W-1:0]        item_w  [0:6];
  logic [ITEM_W-1:0]        snap_ff [0:6];
  logic [3:0]               nibble;

  logic [7:0]               fmt_data;
  logic                     fmt_valid;
  logic                     fmt_ready;
  logic [LVL_W-1:0]         fifo_lvl;

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  mros_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .ce    (pclk_en),
    .din   ({link_gpib_pin, meas_done_pin}),
    .dout  (pins_s)
  );

  assign meas_s = pins_s[0];
  assign gpib_s = pins_s[1];

  // completion is the rising edge of the synchronised done level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_d_ff <= 1'b0;
    end else if (pclk_en) begin
      meas_d_ff <= meas_s;
    end
  end

  assign meas_rise = meas_s & ~meas_d_ff;

  // ----------------------------------------------------------------
  // apb slave, one wait state so every answer comes from a flop
  // ----------------------------------------------------------------
  assign access = psel & penable;
  assign commit = access & pready_ff & pwrite & ~pslverr_ff;

  // read mux and address decode
  always_comb begin
    rd_val = 32'h0000_0000;
    hit    = 1'b1;
    if (paddr == `MROS_OFS_CTRL) begin
      rd_val[`MROS_CTRL_AUTO_BIT] = auto_ff;
    end else if (paddr == `MROS_OFS_MASK) begin
      rd_val[7:0] = mask_ff;
    end else if (paddr == `MROS_OFS_CMD) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == `MROS_OFS_STAT) begin
      rd_val[`MROS_STAT_BUSY_BIT] = (state_ff != mros_pkg::st_idle);
      rd_val[`MROS_STAT_PEND_BIT] = push_pend_ff | query_pend_ff;
      rd_val[`MROS_STAT_OVL_BIT]  = ovl_ff;
      rd_val[`MROS_STAT_GPIB_BIT] = gpib_s;
      rd_val[`MROS_STAT_LVL_LSB +: LVL_W] = fifo_lvl;
    end else begin
      hit = 1'b0;
    end
  end

  // answer registers; unmapped addresses answer with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (pclk_en) begin
      if (access && !pready_ff) begin
        pready_ff  <= 1'b1;
        pslverr_ff <= ~hit;
        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
        pready_ff  <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff  <= 32'h0000_0000;
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // control register: auto push on/off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_ff <= `MROS_RST_AUTO;
    end else if (pclk_en) begin
      if (commit && paddr == `MROS_OFS_CTRL) begin
        auto_ff <= pwdata[`MROS_CTRL_AUTO_BIT];
      end
    end
  end

  // selection mask, full 8 bits kept though bit 7 selects nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= `MROS_RST_MASK;
    end else if (pclk_en) begin
      if (commit && paddr == `MROS_OFS_MASK) begin
        mask_ff <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // request sources
  // ----------------------------------------------------------------
  assign query_evt = commit & (paddr == `MROS_OFS_CMD) &
                     pwdata[`MROS_CMD_QUERY_BIT];
  // gpib link never gets unprompted output
  assign push_evt  = meas_rise & auto_ff & ~gpib_s;
  assign start     = (state_ff == mros_pkg::st_idle) &
                     (push_pend_ff | query_pend_ff);

  // pending requests; a new one in the start cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_pend_ff  <= 1'b0;
      query_pend_ff <= 1'b0;
    end else if (pclk_en) begin
      push_pend_ff  <= push_evt | (push_pend_ff & ~start);
      query_pend_ff <= query_evt | (query_pend_ff & ~start);
    end
  end

  // sticky flag: query while auto push is on may interleave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovl_ff <= 1'b0;
    end else if (pclk_en) begin
      if (query_evt && auto_ff) begin
        ovl_ff <= 1'b1;
      end else if (commit && paddr == `MROS_OFS_STAT &&
                   pwdata[`MROS_STAT_OVL_BIT]) begin
        ovl_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // result formatter, shared by query and push
  // ----------------------------------------------------------------
  // item order follows mask bit order
  always_comb begin
    item_w[0] = item_load_no;
    item_w[1] = item_d_judge;
    item_w[2] = item_d_value;
    item_w[3] = item_c_judge;
    item_w[4] = item_c_value;
    item_w[5] = item_sorting_class;
    item_w[6] = item_status;
  end

  // snapshot at start so a late measurement cannot tear a line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 7; i++) begin
        snap_ff[i] <= '0;
      end
      sel_ff <= 7'h00;
    end else if (pclk_en) begin
      if (start) begin
        for (int i = 0; i < 7; i++) begin
          snap_ff[i] <= item_w[i];
        end
        sel_ff <= mask_ff[6:0] & `MROS_ITEM_MASK;
      end
    end
  end

  assign nibble = snap_ff[idx_ff][{nib_ff, 2'b00} +: 4];

  // next state and output byte
  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_nib   = nib_ff;
    nxt_first = first_ff;
    fmt_valid = 1'b0;
    fmt_data  = 8'h00;
    case (state_ff)
      mros_pkg::st_idle: begin
        if (start) begin
          // one path for both sources keeps the layout identical
          nxt_state = mros_pkg::st_scan;
          nxt_idx   = 3'h0;
          nxt_first = 1'b1;
        end
      end
      mros_pkg::st_scan: begin
        if (idx_ff == `MROS_ITEM_CNT) begin
          nxt_state = mros_pkg::st_term;
        end else if (sel_ff[idx_ff]) begin
          nxt_nib   = NW'(NIB - 1);
          nxt_state = first_ff ? mros_pkg::st_digit
                               : mros_pkg::st_comma;
        end else begin
          nxt_idx = idx_ff + 3'h1;
        end
      end
      mros_pkg::st_comma: begin
        fmt_valid = 1'b1;
        fmt_data  = `MROS_CHR_COMMA;
        if (fmt_ready) begin
          nxt_state = mros_pkg::st_digit;
        end
      end
      mros_pkg::st_digit: begin
        fmt_valid = 1'b1;
        fmt_data  = (nibble < 4'hA) ? `MROS_CHR_ZERO + {4'h0, nibble}
                                    : `MROS_CHR_ALPHA + {4'h0, nibble};
        if (fmt_ready) begin
          if (nib_ff == '0) begin
            nxt_state = mros_pkg::st_scan;
            nxt_idx   = idx_ff + 3'h1;
            nxt_first = 1'b0;
          end else begin
            nxt_nib = nib_ff - 1'b1;
          end
        end
      end
      mros_pkg::st_term: begin
        fmt_valid = 1'b1;
        fmt_data  = `MROS_CHR_TERM;
        if (fmt_ready) begin
          nxt_state = mros_pkg::st_idle;
        end
      end
      default: begin
        nxt_state = mros_pkg::st_idle;
      end
    endcase
  end

  // formatter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= mros_pkg::st_idle;
      idx_ff   <= 3'h0;
      nib_ff   <= '0;
      first_ff <= 1'b1;
    end else if (pclk_en) begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      nib_ff   <= nxt_nib;
      first_ff <= nxt_first;
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo toward the serial transmitter
  // ----------------------------------------------------------------
  mros_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .ce        (pclk_en),
    .in_data   (fmt_data),
    .in_valid  (fmt_valid),
    .in_ready  (fmt_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready & pclk_en),
    .level     (fifo_lvl)
  );

endmodule

// ### sim/measurement_result_output_select_test.sv
// self-checking bench for the result output selector
`timescale 1ns/10ps
`include "mros_defs.svh"
module measurement_result_output_select_test;
  logic        pclk;
  logic        presetn   = 1'b0;
  logic        pclk_en   = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic        meas_done = 1'b0;
  logic        gpib      = 1'b0;
  logic        stall     = 1'b0;
  logic        slow      = 1'b0;
  logic [31:0] prdata, rd;
  logic [7:0]  tx_data;
  logic        pready, pslverr, tx_valid, tx_ready, err;
  logic [15:0] item [7];
  logic [7:0]  rx_q [$];
  logic [7:0]  exp_q [$];
  logic [7:0]  masks [7] = '{8'h14, 8'h7F, 8'h80, 8'h01, 8'h41, 8'h2A, 8'h00};
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc       = 0;

  // ---------------------------------------------------------------
  // design, host and clock
  // ---------------------------------------------------------------
  mros_top #(.ADDR_W(8), .ITEM_W(16), .FIFO_D(8)) mros_top_i (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_done_pin(meas_done), .link_gpib_pin(gpib),
    .item_load_no(item[0]), .item_d_judge(item[1]),
    .item_d_value(item[2]), .item_c_judge(item[3]),
    .item_c_value(item[4]), .item_sorting_class(item[5]),
    .item_status(item[6]), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready)
  );
  mros_host_model mros_host_model_i (
    .pclk(pclk), .presetn(presetn), .stall(stall), .slow(slow),
    .tx_ready(tx_ready)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // distinct item values, letters included to exercise hex digits
  initial begin
    for (int k = 0; k < 7; k++) item[k] = 16'h0F0A + 16'h1111 * k;
  end

  // every byte the host accepts
  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && pclk_en === 1'b1)
      rx_q.push_back(tx_data);
  end

  // hang guard, far above the several hundred cycles the run needs
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // expected line: selected items ascending, comma separated, newline
  function automatic void build(input logic [7:0] m);
    logic [3:0] nib;
    logic       first;
    exp_q.delete();
    first = 1'b1;
    for (int k = 0; k < 7; k++) begin
      if (m[k]) begin
        if (!first) exp_q.push_back(8'h2C);
        first = 1'b0;
        for (int s = 12; s >= 0; s -= 4) begin
          nib = item[k][s +: 4];
          exp_q.push_back(nib < 4'hA ? 8'h30 + nib : 8'h37 + nib);
        end
      end
    end
    exp_q.push_back(8'h0A);
  endfunction

  task automatic cmp_line();
    int   n;
    logic bad;
    n = 0;
    bad = 1'b0;
    while ((rx_q.size() == 0 || rx_q[$] !== 8'h0A) && n < 600) begin
      @(posedge pclk);
      n++;
    end
    checks++;
    if (rx_q.size() != exp_q.size()) bad = 1'b1;
    else foreach (exp_q[i]) if (rx_q[i] !== exp_q[i]) bad = 1'b1;
    if (bad) begin
      error_cnt++;
      $display("[ERR] t=%0t got %h bytes exp %h", $time, rx_q.size(),
               exp_q.size());
    end
    rx_q.delete();
  endtask

  task automatic query(input logic [7:0] m);
    apb(`MROS_OFS_MASK, 1'b1, {24'h0, m});
    apb(`MROS_OFS_CMD, 1'b1, 32'h1);
    build(m);
    cmp_line();
  endtask

  task automatic pulse_done();
    @(posedge pclk);
    meas_done <= 1'b1;
    repeat (6) @(posedge pclk);
    meas_done <= 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(`MROS_OFS_CTRL, 1'b0, 32'h0);
    cmp_word(rd, 32'h0);
    apb(`MROS_OFS_MASK, 1'b0, 32'h0);
    cmp_word(rd, 32'h14);
    apb(`MROS_OFS_STAT, 1'b0, 32'h0);
    cmp_word(rd, 32'h0);
    apb(8'h10, 1'b0, 32'h0);
    cmp_word({err, rd[30:0]}, 32'h80000000);
    apb(`MROS_OFS_MASK, 1'b1, 32'h1FF);
    apb(`MROS_OFS_MASK, 1'b0, 32'h0);
    cmp_word(rd, 32'hFF);
    // each listed mask pattern, host throttled on alternate ones
    foreach (masks[i]) begin
      slow <= i[0];
      query(masks[i]);
    end
    // clock enable low: a pending query freezes before the formatter leaves idle, then runs intact
    apb(`MROS_OFS_MASK, 1'b1, 32'h14);
    apb(`MROS_OFS_CMD, 1'b1, 32'h1);
    pclk_en <= 1'b0;
    repeat (30) @(posedge pclk);
    cmp_word(rx_q.size(), 32'h0);
    pclk_en <= 1'b1;
    build(8'h14);
    cmp_line();
    // host stalls: fifo fills to its depth, then drains losing nothing
    stall <= 1'b1;
    apb(`MROS_OFS_MASK, 1'b1, 32'h7F);
    apb(`MROS_OFS_CMD, 1'b1, 32'h1);
    repeat (60) @(posedge pclk);
    apb(`MROS_OFS_STAT, 1'b0, 32'h0);
    cmp_word({24'h0, rd[7:0]}, 32'h81);
    stall <= 1'b0;
    build(8'h7F);
    cmp_line();
    apb(`MROS_OFS_STAT, 1'b0, 32'h0);
    cmp_word({28'h0, rd[7:4]}, 32'h0);
    // automatic push; host issues no reply-bearing command meanwhile
    apb(`MROS_OFS_MASK, 1'b1, 32'h14);
    apb(`MROS_OFS_CTRL, 1'b1, 32'h1);
    apb(`MROS_OFS_CTRL, 1'b0, 32'h0);
    cmp_word(rd, 32'h1);
    pulse_done();
    build(8'h14);
    cmp_line();
    // query with auto push on sets the sticky overlap flag; write 1 clears
    apb(`MROS_OFS_CMD, 1'b1, 32'h1);
    build(8'h14);
    cmp_line();
    apb(`MROS_OFS_STAT, 1'b0, 32'h0);
    cmp_word({31'h0, rd[2]}, 32'h1);
    apb(`MROS_OFS_STAT, 1'b1, 32'h4);
    apb(`MROS_OFS_STAT, 1'b0, 32'h0);
    cmp_word({31'h0, rd[2]}, 32'h0);
    // gpib link selected: push suppressed
    gpib <= 1'b1;
    repeat (12) @(posedge pclk);
    pulse_done();
    repeat (40) @(posedge pclk);
    cmp_word(rx_q.size(), 32'h0);
    apb(`MROS_OFS_STAT, 1'b0, 32'h0);
    cmp_word({31'h0, rd[3]}, 32'h1);
    gpib <= 1'b0;
    // push disabled: completion stays silent
    apb(`MROS_OFS_CTRL, 1'b1, 32'h0);
    pulse_done();
    repeat (40) @(posedge pclk);
    cmp_word(rx_q.size(), 32'h0);
    end_sim();
  end
endmodule

// ### sim/mros_checker.sv
// port assertions for the result output selector
`timescale 1ns/10ps
`include "mros_defs.svh"
module mros_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              meas_done_pin,
  input wire logic              link_gpib_pin,
  input wire logic [7:0]        tx_data,
  input wire logic              tx_valid,
  input wire logic              tx_ready
);
  logic mapped;

  // decoded address, kept out of the properties for readability
  assign mapped = paddr inside {`MROS_OFS_CTRL, `MROS_OFS_MASK,
                                `MROS_OFS_CMD, `MROS_OFS_STAT};

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_access_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence

  chk_ready_wait: assert property (s_access_wait |=> pready)
    else $error("pready missing after access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  chk_unmapped_err: assert property (s_answer and !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (s_answer and mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_mask_width: assert property (s_answer and (!pwrite &&
      paddr == `MROS_OFS_MASK) |-> prdata[31:8] == 24'h0)
    else $error("mask read wider than eight bits");
  chk_auto_width: assert property (s_answer and (!pwrite &&
      paddr == `MROS_OFS_CTRL) |-> prdata[31:1] == 31'h0)
    else $error("control read has stray bits");

  // ---------------------------------------------------------------
  // result stream
  // ---------------------------------------------------------------
  sequence s_gpib_calm;
    (link_gpib_pin && !psel && !tx_valid) [*8];
  endsequence
  sequence s_gpib_done;
    s_gpib_calm ##1 ($rose(meas_done_pin) && link_gpib_pin && !psel)
      ##1 (link_gpib_pin && !psel) [*8];
  endsequence

  chk_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data))
    else $error("stalled byte changed or vanished");
  chk_gpib_quiet: assert property (s_gpib_done |-> !tx_valid)
    else $error("result pushed while gpib link selected");
endmodule

bind mros_top mros_checker #(.ADDR_W(ADDR_W)) mros_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .meas_done_pin(meas_done_pin),
  .link_gpib_pin(link_gpib_pin), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready)
);

// ### sim/mros_host_model.sv
// serial host model: accepts result bytes, may throttle or stall
`timescale 1ns/10ps
module mros_host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic stall,
  input  wire logic slow,
  output      logic tx_ready
);
  logic phase_ff;

  // ready on alternate cycles when slow, never while stalled;
  // a real uart host drains at its own pace, so pauses are legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      phase_ff <= !phase_ff;
      tx_ready <= !stall && (!slow || phase_ff);
    end
  end
endmodule
